// [sink_burst_pkg.sv]
// Constants shared by the burst sink: widths, field positions, depths, resets.
// Assumes a single clock domain and a fixed lane count.
package sink_burst_pkg;

  // ----------------------------------------------------------------
  // Lane and data widths
  // ----------------------------------------------------------------
  localparam int LANES = 4;
  localparam int WORD_W = 64;
  localparam int DATA_W = WORD_W * LANES;
  localparam int SYNC_W = 8;

  // ----------------------------------------------------------------
  // Error vector layout
  // ----------------------------------------------------------------
  localparam int ERR_W = LANES + 5;
  localparam int ERR_ALIGN = LANES;
  localparam int ERR_UNUSED = LANES + 1;
  localparam int ERR_OVERFLOW = LANES + 2;
  localparam int ERR_SEU_FIXED = LANES + 3;
  localparam int ERR_SEU_FATAL = LANES + 4;

  // ----------------------------------------------------------------
  // FIFO entry layout and depth
  // ----------------------------------------------------------------
  localparam int ENT_FIRST = DATA_W;
  localparam int ENT_LAST = DATA_W + 1;
  localparam int ENT_SYNC_LSB = DATA_W + 2;
  localparam int ENT_W = DATA_W + 2 + SYNC_W;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [ERR_W-1:0] ERR_RESET = '0;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 8'h00;
  localparam logic [SYNC_W-1:0] SYNC_ZERO = 8'h00;

endpackage : sink_burst_pkg

// [sink_error_status.sv]
// Sticky error status with enable-gated interrupt level.
// Assumes clear pulses and error levels on the same clock.
module sink_error_status
  import sink_burst_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Error events, enables and clears
  input wire logic [sink_burst_pkg::ERR_W-1:0] err_in,
  input wire logic [sink_burst_pkg::ERR_W-1:0] irq_enable,
  input wire logic [sink_burst_pkg::ERR_W-1:0] status_clear,
  // Status and interrupt
  output logic [sink_burst_pkg::ERR_W-1:0] status_q,
  output logic irq_q
);

  // Sticky bits: a new event wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      status_q <= ERR_RESET;
    end else begin
      status_q <= err_in | (status_q & ~status_clear);
    end
  end

  // Interrupt high while any enabled bit is set
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & irq_enable);
    end
  end

  property p_irq_rise;
    @(posedge clock) disable iff (rst) (|(status_q & irq_enable)) |=> irq_q;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq not raised for enabled status");

  property p_irq_fall;
    @(posedge clock) disable iff (rst) !(|(status_q & irq_enable)) |=> !irq_q;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq high with no enabled status");

endmodule : sink_error_status

// [sink_fifo.sv]
// Sink adaptation FIFO: small memory with registered read word.
// Assumes one clock, synchronous active-high reset, power-of-two depth.
module sink_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Fill and drain sides
  stream_if.snk wr,
  stream_if.src rd
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q, rd_ptr_q;
  logic [PW:0] count_q, count_d;
  logic wr_ready_q, rd_valid_q;
  logic [WIDTH-1:0] rd_data_q;
  logic push, pop;

  // Handshakes: pop moves the head into the read register
  assign push = wr.valid && wr_ready_q;
  assign pop = (count_q != '0) && (!rd_valid_q || rd.ready);
  assign count_d = count_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
  assign wr.ready = wr_ready_q;
  assign rd.valid = rd_valid_q;
  assign rd.data = rd_data_q;

  // Storage array
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_ptr_q] <= wr.data;
    end
  end

  // Pointers, fill count and honest ready
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      wr_ready_q <= 1'b0;
    end else begin
      wr_ptr_q <= wr_ptr_q + PW'(push);
      rd_ptr_q <= rd_ptr_q + PW'(pop);
      count_q <= count_d;
      wr_ready_q <= (count_d < (PW+1)'(DEPTH));
    end
  end

  // Registered read word
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_valid_q <= 1'b0;
      rd_data_q <= '0;
    end else if (pop) begin
      rd_valid_q <= 1'b1;
      rd_data_q <= mem_q[rd_ptr_q];
    end else if (rd.ready) begin
      rd_valid_q <= 1'b0;
    end
  end

endmodule : sink_fifo

// [sink_user_model.sv]
// User logic model on the far side of the sink: takes words, may hold off or drop ready.
// Assumes the sink's clock and its synchronous active-high reset.
module sink_user_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Sink side
  input wire logic sink_valid,
  input wire logic sink_link_up,
  output logic sink_ready,
  output logic take,
  // Commands from the bench
  input wire logic stall,
  input wire logic drop
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Ready rises once stall ends and falls only on command
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      sink_ready <= 1'b0;
    end else if (drop) begin
      sink_ready <= 1'b0;
    end else if (!stall) begin
      sink_ready <= 1'b1;
    end
  end
  // Words count only while the link is up
  assign take = sink_valid && sink_ready && sink_link_up;
endmodule : sink_user_model

// [stream_if.sv]
// Valid/ready word carrier between the sink's own modules.
// Assumes both ends on the same clock.
interface stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;

  // Producer side
  modport src (output valid, output data, input ready);
  // Consumer side
  modport snk (input valid, input data, output ready);
endinterface : stream_if

// [stream_sink_burst_status.sv]
// Sink user interface of a multi-lane streaming link: burst flags, error vector, interrupt.
// Assumes received words arrive on clock already; the injection input is asynchronous.
module stream_sink_burst_status
  import sink_burst_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Configuration
  input wire logic burst_mode,
  input wire logic ecc_enable,
  input wire logic advanced_clocking,
  // Received words from the link
  input wire logic in_valid,
  input wire logic [sink_burst_pkg::DATA_W-1:0] in_data,
  input wire logic in_first,
  input wire logic in_last,
  input wire logic [sink_burst_pkg::SYNC_W-1:0] in_sync,
  output logic in_ready,
  // Link condition reports
  input wire logic link_up,
  input wire logic [sink_burst_pkg::LANES-1:0] lane_sync_header_err,
  input wire logic [sink_burst_pkg::LANES-1:0] lane_multiframe_err,
  input wire logic [sink_burst_pkg::LANES-1:0] lane_crc_err,
  input wire logic align_lost,
  input wire logic single_event_upset_fixed,
  input wire logic single_event_upset_fatal,
  // Test input from the transmit side
  input wire logic crc_error_inject,
  // Sink user interface
  input wire logic sink_ready,
  output logic sink_valid,
  output logic [sink_burst_pkg::DATA_W-1:0] sink_data,
  output logic sink_burst_first,
  output logic sink_burst_last,
  output logic [sink_burst_pkg::SYNC_W-1:0] sink_sync,
  output logic sink_link_up,
  output logic [sink_burst_pkg::ERR_W-1:0] sink_error,
  output logic sink_ready_drop,
  // Status and interrupt
  input wire logic [sink_burst_pkg::ERR_W-1:0] irq_enable,
  input wire logic [sink_burst_pkg::ERR_W-1:0] status_clear,
  output logic [sink_burst_pkg::ERR_W-1:0] err_status,
  output logic err_interrupt
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Upset flags count only with correction on and standard clocking
  function automatic logic upset_qualify(input logic flag, input logic ecc, input logic adv);
    upset_qualify = flag && ecc && !adv;
  endfunction : upset_qualify

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  stream_if #(.W(ENT_W)) wr_if ();
  stream_if #(.W(ENT_W)) rd_if ();

  logic inject_meta_q, inject_q;
  logic overflow;
  logic rd_fire;
  logic sink_fire;
  logic [ERR_W-1:0] err_d;
  logic [ERR_W-1:0] sink_error_q;
  logic sink_valid_q, sink_first_q, sink_last_q, sink_link_up_q;
  logic [DATA_W-1:0] sink_data_q;
  logic [SYNC_W-1:0] sink_sync_q, entry_sync;
  logic seen_data_q;
  logic burst_open_q;
  logic sink_ready_prev_q;
  logic ready_drop_q;
  logic ready_drop_now;
  logic [ERR_W-1:0] status_q;
  logic irq_q;

  // ----------------------------------------------------------------
  // Injection synchroniser
  // ----------------------------------------------------------------

  // Two flops before the injection level is used
  always_ff @(posedge clock) begin
    if (rst) begin
      inject_meta_q <= 1'b0;
      inject_q <= 1'b0;
    end else begin
      inject_meta_q <= crc_error_inject;
      inject_q <= inject_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Adaptation FIFO
  // ----------------------------------------------------------------

  // Pack data, framing flags and sync into one entry
  assign wr_if.valid = in_valid;
  assign wr_if.data = {in_sync, in_last, in_first, in_data};
  assign in_ready = wr_if.ready;
  assign overflow = in_valid && !wr_if.ready;

  sink_fifo #(
    .WIDTH(ENT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst(rst),
    .wr(wr_if),
    .rd(rd_if)
  );

  // Drain when the output stage is empty or being taken
  assign rd_if.ready = !sink_valid_q || sink_ready;
  assign rd_fire = rd_if.valid && rd_if.ready;
  assign sink_fire = sink_valid_q && sink_ready;

  // Single lane never has invalid words at burst end
  assign entry_sync = (LANES == 1 && rd_if.data[ENT_LAST]) ? SYNC_ZERO
                    : rd_if.data[ENT_SYNC_LSB +: SYNC_W];

  // ----------------------------------------------------------------
  // Sink output stage
  // ----------------------------------------------------------------

  // Word, sync and valid held until the user takes them
  always_ff @(posedge clock) begin
    if (rst) begin
      sink_valid_q <= 1'b0;
      sink_data_q <= '0;
      sink_sync_q <= SYNC_RESET;
    end else if (rd_fire) begin
      sink_valid_q <= 1'b1;
      sink_data_q <= rd_if.data[DATA_W-1:0];
      sink_sync_q <= entry_sync;
    end else if (sink_ready) begin
      sink_valid_q <= 1'b0;
    end
  end

  // Start and end of burst flags travel with their word
  always_ff @(posedge clock) begin
    if (rst) begin
      sink_first_q <= 1'b0;
      sink_last_q <= 1'b0;
    end else if (rd_fire) begin
      if (burst_mode) begin
        sink_first_q <= rd_if.data[ENT_FIRST];
      end else begin
        sink_first_q <= !seen_data_q;
      end
      sink_last_q <= rd_if.data[ENT_LAST];
    end else if (sink_ready) begin
      sink_first_q <= 1'b0;
      sink_last_q <= 1'b0;
    end
  end

  // Continuous stream marks its start only once
  always_ff @(posedge clock) begin
    if (rst) begin
      seen_data_q <= 1'b0;
    end else if (rd_fire && !burst_mode) begin
      seen_data_q <= 1'b1;
    end
  end

  // Link-up follows the link; user masks data while low
  always_ff @(posedge clock) begin
    if (rst) begin
      sink_link_up_q <= 1'b0;
    end else begin
      sink_link_up_q <= link_up;
    end
  end

  // ----------------------------------------------------------------
  // Ready drop detection
  // ----------------------------------------------------------------

  // Burst open from first taken word until last taken word
  always_ff @(posedge clock) begin
    if (rst) begin
      burst_open_q <= 1'b0;
    end else if (sink_fire && sink_last_q) begin
      burst_open_q <= 1'b0;
    end else if (sink_fire && sink_first_q) begin
      burst_open_q <= 1'b1;
    end
  end

  assign ready_drop_now = sink_ready_prev_q && !sink_ready && (burst_open_q || sink_valid_q);

  // Sticky flag for ready falling mid-transfer
  always_ff @(posedge clock) begin
    if (rst) begin
      sink_ready_prev_q <= 1'b0;
      ready_drop_q <= 1'b0;
    end else begin
      sink_ready_prev_q <= sink_ready;
      ready_drop_q <= ready_drop_q || ready_drop_now;
    end
  end

  // ----------------------------------------------------------------
  // Error vector
  // ----------------------------------------------------------------

  // Assemble per-lane and aggregate error bits
  always_comb begin
    err_d = ERR_RESET;
    err_d[LANES-1:0] = lane_sync_header_err | lane_multiframe_err
                     | lane_crc_err | {LANES{inject_q}};
    err_d[ERR_ALIGN] = align_lost;
    err_d[ERR_UNUSED] = 1'b0;
    err_d[ERR_OVERFLOW] = overflow && !advanced_clocking;
    err_d[ERR_SEU_FIXED] = upset_qualify(single_event_upset_fixed, ecc_enable, advanced_clocking);
    err_d[ERR_SEU_FATAL] = upset_qualify(single_event_upset_fatal, ecc_enable, advanced_clocking);
  end

  // Registered error vector
  always_ff @(posedge clock) begin
    if (rst) begin
      sink_error_q <= ERR_RESET;
    end else begin
      sink_error_q <= err_d;
    end
  end

  // ----------------------------------------------------------------
  // Status and interrupt
  // ----------------------------------------------------------------
  sink_error_status u_status (
    .clock(clock),
    .rst(rst),
    .err_in(sink_error_q),
    .irq_enable(irq_enable),
    .status_clear(status_clear),
    .status_q(status_q),
    .irq_q(irq_q)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sink_valid = sink_valid_q;
  assign sink_data = sink_data_q;
  assign sink_burst_first = sink_first_q;
  assign sink_burst_last = sink_last_q;
  assign sink_sync = sink_sync_q;
  assign sink_link_up = sink_link_up_q;
  assign sink_error = sink_error_q;
  assign sink_ready_drop = ready_drop_q;
  assign err_status = status_q;
  assign err_interrupt = irq_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  sequence s_burst_head_taken;
    rd_fire && burst_mode && rd_if.data[ENT_FIRST];
  endsequence

  sequence s_flag_shown;
    ##1 (sink_valid_q && sink_first_q);
  endsequence

  property p_first_with_head;
    @(posedge clock) disable iff (rst) s_burst_head_taken |-> s_flag_shown;
  endproperty
  a_first_with_head: assert property (p_first_with_head) else $error("burst head without first flag");

  property p_first_needs_valid;
    @(posedge clock) disable iff (rst) sink_first_q |-> sink_valid_q;
  endproperty
  a_first_needs_valid: assert property (p_first_needs_valid) else $error("first flag without valid");

  property p_cont_first_once;
    @(posedge clock) disable iff (rst) (rd_fire && !burst_mode && seen_data_q) |=> !sink_first_q;
  endproperty
  a_cont_first_once: assert property (p_cont_first_once) else $error("continuous first repeated");

  property p_last_with_tail;
    @(posedge clock) disable iff (rst) (rd_fire && rd_if.data[ENT_LAST]) |=> (sink_valid_q && sink_last_q);
  endproperty
  a_last_with_tail: assert property (p_last_with_tail) else $error("tail word without last flag");

  property p_no_spurious_last;
    @(posedge clock) disable iff (rst) (rd_fire && !rd_if.data[ENT_LAST]) |=> !sink_last_q;
  endproperty
  a_no_spurious_last: assert property (p_no_spurious_last) else $error("last flag not sent by sender");

  property p_unused_zero;
    @(posedge clock) disable iff (rst) sink_error_q[ERR_UNUSED] == 1'b0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused error bit not zero");

  property p_overflow_flag;
    @(posedge clock) disable iff (rst) (overflow && !advanced_clocking) |=> sink_error_q[ERR_OVERFLOW];
  endproperty
  a_overflow_flag: assert property (p_overflow_flag) else $error("overflow not flagged");

  property p_seu_fixed;
    @(posedge clock) disable iff (rst)
      (single_event_upset_fixed && ecc_enable && !advanced_clocking) |=> sink_error_q[ERR_SEU_FIXED];
  endproperty
  a_seu_fixed: assert property (p_seu_fixed) else $error("corrected upset not flagged");

  property p_seu_fatal_adv;
    @(posedge clock) disable iff (rst) advanced_clocking |=> !sink_error_q[ERR_SEU_FATAL];
  endproperty
  a_seu_fatal_adv: assert property (p_seu_fatal_adv) else $error("upset bit set in advanced clocking");

  property p_align_flag;
    @(posedge clock) disable iff (rst) align_lost |=> sink_error_q[ERR_ALIGN];
  endproperty
  a_align_flag: assert property (p_align_flag) else $error("alignment loss not flagged");

  property p_lane_crc;
    @(posedge clock) disable iff (rst) lane_crc_err[0] |=> sink_error_q[0];
  endproperty
  a_lane_crc: assert property (p_lane_crc) else $error("lane crc fault not flagged");

  property p_inject_path;
    @(posedge clock) disable iff (rst) crc_error_inject |-> ##3 sink_error_q[0];
  endproperty
  a_inject_path: assert property (p_inject_path) else $error("injection did not corrupt crc");

  property p_ready_drop;
    @(posedge clock) disable iff (rst) ready_drop_now |=> ready_drop_q;
  endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("ready drop not flagged");

  property p_single_lane_sync;
    @(posedge clock) disable iff (rst) (LANES == 1 && sink_valid_q && sink_last_q) |-> sink_sync_q == SYNC_ZERO;
  endproperty
  a_single_lane_sync: assert property (p_single_lane_sync) else $error("single lane sync not zero");

endmodule : stream_sink_burst_status

// [testbench.sv]
// Bench for the burst sink: word stream, error vector, sticky status and interrupt.
// Assumes the sink package, the design and the user logic model are compiled first.
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import sink_burst_pkg::*;
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic first;
    logic last;
    logic [SYNC_W-1:0] sync;
  } word_type;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clock, rst, burst_mode, ecc_enable, advanced_clocking, in_valid, in_first, in_last, in_ready;
  logic [DATA_W-1:0] in_data, sink_data;
  logic [SYNC_W-1:0] in_sync, sink_sync;
  logic [LANES-1:0] lane_sync_header_err, lane_multiframe_err, lane_crc_err;
  logic link_up, align_lost, single_event_upset_fixed, single_event_upset_fatal, crc_error_inject;
  logic sink_ready, sink_valid, sink_burst_first, sink_burst_last, sink_link_up, sink_ready_drop;
  logic [ERR_W-1:0] sink_error, irq_enable, status_clear, err_status;
  logic err_interrupt, take, stall, drop, first_due, t;
  word_type expect_q[$];
  word_type w, exp_w;
  int mismatches = 0;
  int samples_checked = 0;
  int seed = 10;
  int n;
  stream_sink_burst_status stream_sink_burst_status_inst (.*);
  sink_user_model sink_user_model_inst (.*);
  // Clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic do_reset(input logic mode);
    rst <= 1'b1;
    burst_mode <= mode;
    first_due = 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : do_reset
  // One word offered for one edge; notes it when taken
  task automatic push(input logic f, input logic l, output logic taken);
    logic [SYNC_W-1:0] s;
    for (int i = 0; i < DATA_W / 32; i++) w.data[i*32 +: 32] = $random(seed);
    s = SYNC_W'($random(seed));
    w.first = burst_mode ? f : first_due;
    w.last = l;
    w.sync = (LANES == 1 && l) ? SYNC_ZERO : s;
    in_valid <= 1'b1;
    in_data <= w.data;
    in_first <= f;
    in_last <= l;
    in_sync <= s;
    @(posedge clock);
    taken = in_ready;
    if (taken) begin
      expect_q.push_back(w);
      first_due = 1'b0;
    end
  endtask : push
  // Back-to-back bursts of random length, one to four words
  task automatic bursts(input int count);
    int len;
    for (int b = 0; b < count; b++) begin
      len = 1 + ($unsigned($random(seed)) % 4);
      for (int i = 0; i < len; i++) begin
        push(i == 0 || $random(seed) % 2 == 0, i == len - 1, t);
        `CHK("in_ready", 1'b1, t)
      end
    end
    in_valid <= 1'b0;
  endtask : bursts
  task automatic wait_empty();
    for (int i = 0; i < 200 && expect_q.size() > 0; i++) @(posedge clock);
    `CHK("words left", 0, expect_q.size())
  endtask : wait_empty
  // One condition for one cycle, then the error vector it leaves
  task automatic err_case(input int k, input int ln);
    logic [ERR_W-1:0] e;
    e = '0;
    lane_sync_header_err[ln] <= (k == 0);
    lane_multiframe_err[ln] <= (k == 1);
    lane_crc_err[ln] <= (k == 2);
    align_lost <= (k == 3);
    single_event_upset_fixed <= (k == 4);
    single_event_upset_fatal <= (k == 5);
    e[ln] = (k < 3);
    e[ERR_ALIGN] = (k == 3);
    e[ERR_SEU_FIXED] = (k == 4) && ecc_enable && !advanced_clocking;
    e[ERR_SEU_FATAL] = (k == 5) && ecc_enable && !advanced_clocking;
    @(posedge clock);
    lane_sync_header_err <= '0;
    lane_multiframe_err <= '0;
    lane_crc_err <= '0;
    align_lost <= 1'b0;
    single_event_upset_fixed <= 1'b0;
    single_event_upset_fatal <= 1'b0;
    #1;
    `CHK("sink_error", e, sink_error)
    @(posedge clock);
  endtask : err_case
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out
  // Compare each word the user model takes with the oldest note
  always @(posedge clock) begin
    if (!rst && take) begin
      exp_w = expect_q.pop_front();
      `CHK("sink_data", exp_w.data, sink_data)
      `CHK("sink_burst_first", exp_w.first, sink_burst_first)
      `CHK("sink_burst_last", exp_w.last, sink_burst_last)
      `CHK("sink_sync", exp_w.sync, sink_sync)
    end
  end
  // Watchdog
  initial begin
    #2000000;
    mismatches++;
    close_out();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, burst_mode, stall} = 3'b111;
    {ecc_enable, advanced_clocking, in_valid, in_first, in_last, link_up, drop} = '0;
    {align_lost, single_event_upset_fixed, single_event_upset_fatal, crc_error_inject} = '0;
    {lane_sync_header_err, lane_multiframe_err, lane_crc_err} = '0;
    {in_data, in_sync, irq_enable, status_clear} = '0;
    do_reset(1'b1);
    #1;
    `CHK("outputs after reset", '0, {sink_valid, sink_link_up, sink_error, err_status, err_interrupt, sink_ready_drop})
    `CHK("error width", LANES + 5, $bits(sink_error))
    // Fill the buffer while the user stalls, then one word too many
    @(posedge clock);
    link_up <= 1'b1;
    n = 0;
    t = 1'b1;
    while (t && n < 20) begin
      push(n == 0, 1'b0, t);
      n++;
    end
    in_valid <= 1'b0;
    #1;
    `CHK("overflow bit", 1'b1, sink_error[ERR_OVERFLOW])
    `CHK("words held", 1'b1, n > FIFO_DEPTH)
    `CHK("sink_link_up", 1'b1, sink_link_up)
    @(posedge clock);
    stall <= 1'b0;
    wait_empty();
    bursts(8);
    wait_empty();
    // Continuous operation: first flag once after reset
    do_reset(1'b0);
    bursts(5);
    wait_empty();
    // Error vector under every correction and clocking setting
    for (int c = 0; c < 4; c++) begin
      ecc_enable <= c[0];
      advanced_clocking <= c[1];
      @(posedge clock);
      for (int k = 0; k < 6; k++) err_case(k, (k + c) % LANES);
    end
    ecc_enable <= 1'b0;
    advanced_clocking <= 1'b0;
    crc_error_inject <= 1'b1;
    @(posedge clock);
    crc_error_inject <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    `CHK("injected error", ERR_W'({LANES{1'b1}}), sink_error)
    // Interrupt: two enabled bits and one masked bit
    @(posedge clock);
    irq_enable <= ERR_W'(1) | (ERR_W'(1) << ERR_ALIGN);
    status_clear <= '1;
    @(posedge clock);
    status_clear <= '0;
    align_lost <= 1'b1;
    lane_crc_err <= 4'h3;
    @(posedge clock);
    align_lost <= 1'b0;
    lane_crc_err <= '0;
    repeat (2) @(posedge clock);
    #1;
    `CHK("err_status", ERR_W'(3) | (ERR_W'(1) << ERR_ALIGN), err_status)
    `CHK("err_interrupt", 1'b1, err_interrupt)
    for (int j = 0; j < 2; j++) begin
      @(posedge clock);
      status_clear <= (j == 0) ? (ERR_W'(1) << ERR_ALIGN) : ERR_W'(1);
      @(posedge clock);
      status_clear <= '0;
      @(posedge clock);
      #1;
      `CHK("err_interrupt", j == 0, err_interrupt)
    end
    `CHK("err_status", ERR_W'(2), err_status)
    // Ready dropped while a burst is open
    `CHK("sink_ready_drop", 1'b0, sink_ready_drop)
    // Burst mode so the head word opens a burst
    burst_mode <= 1'b1;
    @(posedge clock);
    push(1'b1, 1'b0, t);
    in_valid <= 1'b0;
    wait_empty();
    drop <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
    `CHK("sink_ready_drop", 1'b1, sink_ready_drop)
    close_out();
  end
endmodule : testbench
